//--- adc_converter_model.sv
// behavioural converter that answers each active slot with a one-cycle done pulse
// assumes convSlot comes straight from adc_range_ctrl on the same clock
`timescale 1ns/1ps
module adc_converter_model (
  input  wire logic                      clk,       // device clock
  input  wire logic                      reset_n,   // async reset, active low
  input  wire adc_range_pkg::conv_slot_t convSlot,  // slot being converted
  input  wire logic [3:0]                latency,   // extra cycles before done
  output logic                           convDone   // slot finished pulse
);
  logic [3:0] waitCnt;  // cycles spent on the current slot

  // the pulse drops at the edge the controller takes it, so a slot is never answered twice
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitCnt  <= 4'h0;
      convDone <= 1'b0;
    end else if (convDone) begin
      waitCnt  <= 4'h0;
      convDone <= 1'b0;
    end else if (convSlot.active) begin
      if (waitCnt >= latency) convDone <= 1'b1;
      else waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule : adc_converter_model

//--- adc_range_cfg.svh
// constants for the converter channel, range and dac alarm-clear configuration block
// assumes a 16-bit register port with byte-wide addresses on the device clock
//
// Overview of operation
// R01 - both pair single-ended bits set: convert both channels single-ended, ignore pair bit
// R02 - channel 0 minus 1 differential only when both single-ended clear and pair bit set
// R03 - one single-ended bit of a pair: convert that channel only, skip partner
// R04 - channel 2 minus 3 differential only when both single-ended clear and pair bit set
// R05 - all three bits of a pair clear: nothing of that pair is converted
// R06 - low select bits 8 to 0 enable channels 4 to 12 independently
// R07 - high select register 51h bits 14:12 enable channels 13-15; others read zero
// R08 - convert order: low register bit 14 down to 0, then high bits 14 to 12
// R09 - single-ended results go to own result register, unsigned straight binary
// R10 - range bit 15 doubles channel 0 and pair 0/1 span; reset FFFFh at 52h
// R11 - range bit 13 doubles channel 2 and pair 2/3 span
// R12 - range bits 14, 12, 11:0 double span of channels 1, 3, 4 to 15
// R13 - clear-source register 53h, reset 0004h, acts in auto and manual dac modes
// R14 - dac forced clear when source bit, its auto-clear enable and alarm flag all set
// R15 - source bit zero: flag still raised, but no dac forced clear
// R16 - clear-source bit 15 ignores writes and reads zero
// R17 - auto-clear enables at 54h bits 14:3, one per dac
// R18 - channel 0 flag set while channel 0 or pair 0/1 is out of window
// R19 - differential results go to lower channel register in two's complement
// R20 - select and range changes take effect from the next conversion sequence
`ifndef ADC_RANGE_CFG_SVH
`define ADC_RANGE_CFG_SVH

// register addresses
`define CHAN_SEL_LO_ADDR   8'h50
`define CHAN_SEL_HI_ADDR   8'h51
`define RANGE_SEL_ADDR     8'h52
`define CLR_SOURCE_ADDR    8'h53
`define AUTO_CLR_EN_ADDR   8'h54

// reset values
`define CHAN_SEL_LO_RST    16'h0000
`define CHAN_SEL_HI_RST    16'h0000
`define RANGE_SEL_RST      16'hFFFF
`define CLR_SOURCE_RST     16'h0004
`define AUTO_CLR_EN_RST    16'h0000

// writable bits; everything else reads zero
`define CHAN_SEL_LO_MASK   16'h7FFF
`define CHAN_SEL_HI_MASK   16'h7000
`define RANGE_SEL_MASK     16'hFFFF
`define CLR_SOURCE_MASK    16'h7FFC
`define AUTO_CLR_EN_MASK   16'h7FF8

// field positions
`define SEL_SE0_BIT        14
`define SEL_SE1_BIT        13
`define SEL_DF01_BIT       12
`define SEL_SE2_BIT        11
`define SEL_SE3_BIT        10
`define SEL_DF23_BIT       9
`define CLR_THERM_BIT      2
`define DAC_EN_LSB         3
`define DAC_COUNT          12

// conversion slots in sequence order
`define SLOT_COUNT         18
`define SLOT_DF01          5'h02
`define SLOT_DF23          5'h05

`endif

//--- adc_range_ctrl.sv
// channel select, conversion sequencing, input range and dac alarm-clear logic
// assumes register strobes and alarm conditions come from logic on clk;
// the converter answers each slot with a one-cycle convDone
`timescale 1ns/1ps
`include "adc_range_cfg.svh"
module adc_range_ctrl (
  input  wire logic                     clk,            // 40 MHz device clock
  input  wire logic                     reset_n,        // async reset, active low
  input  wire adc_range_pkg::reg_req_t  regReq,         // register access
  output logic [15:0]                   regRdData,      // read data, cycle after rdEn
  input  wire logic                     seqStart,       // start a conversion sequence
  input  wire logic                     convDone,       // current slot finished
  output adc_range_pkg::conv_slot_t     convSlot,       // slot being converted
  output logic                          seqDone,        // sequence finished pulse
  input  wire logic [14:2]              alarmCond,      // out-of-window conditions
  output logic [14:2]                   alarmFlag,      // registered alarm flags
  output logic [11:0]                   dacForceClear   // per-dac forced clear
);

  logic [15:0]               chanSelLo_r;
  logic [15:0]               chanSelHi_r;
  logic [15:0]               rangeSel_r;
  logic [15:0]               clrSource_r;
  logic [15:0]               autoClrEn_r;
  logic [15:0]               regRdData_r;
  logic [15:0]               regRdData_nxt;
  adc_range_pkg::seq_state_t state_r;
  logic [17:0]               maskSnap_r;
  logic [15:0]               rangeSnap_r;
  logic [4:0]                slotIdx_r;
  adc_range_pkg::conv_slot_t convSlot_r;
  adc_range_pkg::conv_slot_t convSlot_nxt;
  logic                      seqDone_r;
  logic [14:2]               alarmFlag_r;
  logic [11:0]               dacForceClear_r;
  logic [11:0]               dacForceClear_nxt;

  // address decode
  wire hitLo    = regReq.addr == `CHAN_SEL_LO_ADDR;
  wire hitHi    = regReq.addr == `CHAN_SEL_HI_ADDR;
  wire hitRange = regReq.addr == `RANGE_SEL_ADDR;
  wire hitSrc   = regReq.addr == `CLR_SOURCE_ADDR;
  wire hitEn    = regReq.addr == `AUTO_CLR_EN_ADDR;

  // register writes; masks keep reserved bits at zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chanSelLo_r <= `CHAN_SEL_LO_RST;
      chanSelHi_r <= `CHAN_SEL_HI_RST;
      rangeSel_r  <= `RANGE_SEL_RST;              // see R10
      clrSource_r <= `CLR_SOURCE_RST;             // see R13
      autoClrEn_r <= `AUTO_CLR_EN_RST;
    end else if (regReq.wrEn) begin
      if (hitLo)    chanSelLo_r <= regReq.wrData & `CHAN_SEL_LO_MASK;
      if (hitHi)    chanSelHi_r <= regReq.wrData & `CHAN_SEL_HI_MASK;   // see R07
      if (hitRange) rangeSel_r  <= regReq.wrData & `RANGE_SEL_MASK;
      if (hitSrc)   clrSource_r <= regReq.wrData & `CLR_SOURCE_MASK;    // see R16
      if (hitEn)    autoClrEn_r <= regReq.wrData & `AUTO_CLR_EN_MASK;   // see R17
    end
  end

  // read mux; unmapped addresses answer zero
  assign regRdData_nxt = hitLo    ? chanSelLo_r :
                         hitHi    ? chanSelHi_r :
                         hitRange ? rangeSel_r  :
                         hitSrc   ? clrSource_r :
                         hitEn    ? autoClrEn_r : 16'h0000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) regRdData_r <= 16'h0000;
    else if (regReq.rdEn) regRdData_r <= regRdData_nxt;
  end

  // pair decode for channels 0/1 and 2/3
  logic en0, en1, enDf01, en2, en3, enDf23;

  pair_decode u_pair01 (
    .seA    (chanSelLo_r[`SEL_SE0_BIT]),
    .seB    (chanSelLo_r[`SEL_SE1_BIT]),
    .dfSel  (chanSelLo_r[`SEL_DF01_BIT]),
    .enA    (en0),
    .enB    (en1),
    .enDiff (enDf01)
  );

  pair_decode u_pair23 (
    .seA    (chanSelLo_r[`SEL_SE2_BIT]),
    .seB    (chanSelLo_r[`SEL_SE3_BIT]),
    .dfSel  (chanSelLo_r[`SEL_DF23_BIT]),
    .enA    (en2),
    .enB    (en3),
    .enDiff (enDf23)
  );

  // slots in sequence order: low register bit 14 first, high register last
  wire [8:0]  seLoRev = {<<{chanSelLo_r[8:0]}};               // see R06
  wire [2:0]  seHiRev = {<<{chanSelHi_r[14:12]}};             // see R07
  wire [17:0] slotMaskLive = {seHiRev, seLoRev, enDf23, en3, en2, enDf01, en1, en0};  // see R08

  // slot index to channel: differential slots report the lower channel
  function automatic logic [3:0] slotChannel(input logic [4:0] s);
    logic [4:0] c;
    c = 5'h00;
    if (s == `SLOT_DF01)      c = 5'h00;      // see R19
    else if (s == `SLOT_DF23) c = 5'h02;      // see R19
    else if (s < `SLOT_DF01)  c = s;
    else if (s < `SLOT_DF23)  c = s - 5'h01;
    else                      c = s - 5'h02;
    return c[3:0];
  endfunction : slotChannel

  // picker looks at the live mask when starting, the snapshot when advancing
  wire        idle      = state_r == adc_range_pkg::seqIdle;
  wire [17:0] pickMask  = idle ? slotMaskLive : maskSnap_r;
  wire [4:0]  pickFrom  = idle ? 5'h00 : slotIdx_r + 5'h01;
  wire [15:0] pickRange = idle ? rangeSel_r : rangeSnap_r;
  wire        pickFound;
  wire [4:0]  pickIdx;

  slot_picker u_picker (
    .mask    (pickMask),
    .fromIdx (pickFrom),
    .found   (pickFound),
    .pickIdx (pickIdx)
  );

  wire [3:0] pickChan = slotChannel(pickIdx);
  wire       pickDiff = (pickIdx == `SLOT_DF01) || (pickIdx == `SLOT_DF23);
  wire       startNow = idle && seqStart;
  wire       stepNow  = !idle && convDone;

  // range bit 15 is channel 0 down to bit 0 for channel 15
  always_comb begin
    convSlot_nxt              = convSlot_r;
    convSlot_nxt.active       = pickFound;
    convSlot_nxt.channel      = pickChan;
    convSlot_nxt.diff         = pickDiff;
    convSlot_nxt.rangeDouble  = pickRange[4'hF - pickChan];    // see R10 see R11 see R12
    convSlot_nxt.signedResult = pickDiff;                      // see R09 see R19
  end

  // sequencer; select and range are frozen for the whole sequence
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r     <= adc_range_pkg::seqIdle;
      maskSnap_r  <= 18'h00000;
      rangeSnap_r <= `RANGE_SEL_RST;
      slotIdx_r   <= 5'h00;
      convSlot_r  <= '0;
      seqDone_r   <= 1'b0;
    end else begin
      seqDone_r <= (startNow || stepNow) && !pickFound;
      if (startNow) begin
        maskSnap_r  <= slotMaskLive;                            // see R20
        rangeSnap_r <= rangeSel_r;                              // see R20
      end
      if (startNow || stepNow) begin
        state_r    <= pickFound ? adc_range_pkg::seqConvert : adc_range_pkg::seqIdle;
        slotIdx_r  <= pickFound ? pickIdx : 5'h00;
        convSlot_r <= pickFound ? convSlot_nxt : '0;
      end
    end
  end

  // dac clear: any enabled source with its flag set hits dacs whose enable is set;
  // the thermal source ignores the per-dac enables and clears every dac
  wire [14:3] srcHit   = clrSource_r[14:3] & alarmFlag_r[14:3];    // see R14 see R15
  wire        anyHit   = |srcHit;
  wire        thermHit = clrSource_r[`CLR_THERM_BIT] & alarmFlag_r[`CLR_THERM_BIT];
  assign dacForceClear_nxt = ({`DAC_COUNT{anyHit}} & autoClrEn_r[14:`DAC_EN_LSB])
                           | {`DAC_COUNT{thermHit}};               // see R14 see R17

  // flags follow the condition with no dependency on the clear source; no dac mode
  // input exists, so the clear applies whatever mode the dacs run in
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alarmFlag_r     <= '0;
      dacForceClear_r <= 12'h000;
    end else begin
      alarmFlag_r     <= alarmCond;                                // see R18 see R15
      dacForceClear_r <= dacForceClear_nxt;                        // see R13
    end
  end

  assign regRdData     = regRdData_r;
  assign convSlot      = convSlot_r;
  assign seqDone       = seqDone_r;
  assign alarmFlag     = alarmFlag_r;
  assign dacForceClear = dacForceClear_r;

  // checks on decode, sequencing, registers and clear logic
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_BOTH_SE01: assert property (                                 // see R01
    chanSelLo_r[`SEL_SE0_BIT] && chanSelLo_r[`SEL_SE1_BIT] |->
      slotMaskLive[0] && slotMaskLive[1] && !slotMaskLive[2])
    else $error("pair 0/1 both single-ended decoded wrong");

  AST_DIFF01: assert property (                                    // see R02
    slotMaskLive[2] == (chanSelLo_r[12] && !chanSelLo_r[14] && !chanSelLo_r[13]))
    else $error("pair 0/1 differential decode wrong");

  AST_ONE_SE: assert property (                                    // see R03
    (chanSelLo_r[11] ^ chanSelLo_r[10]) |->
      !slotMaskLive[5] && (slotMaskLive[3] == chanSelLo_r[11]))
    else $error("single channel of pair 2/3 decoded wrong");

  AST_DIFF23: assert property (                                    // see R04
    slotMaskLive[5] == (chanSelLo_r[9] && !chanSelLo_r[11] && !chanSelLo_r[10]))
    else $error("pair 2/3 differential decode wrong");

  AST_PAIR_OFF: assert property (                                  // see R05
    chanSelLo_r[14:12] == 3'h0 |-> slotMaskLive[2:0] == 3'h0)
    else $error("empty pair still converts");

  AST_SE_LOW: assert property (                                    // see R06
    slotMaskLive[6] == chanSelLo_r[8] && slotMaskLive[14] == chanSelLo_r[0])
    else $error("channel 4 or 12 enable misplaced");

  AST_HI_READ: assert property (                                   // see R07
    regReq.rdEn && hitHi |=> regRdData[15] == 1'b0 && regRdData[11:0] == 12'h000)
    else $error("high select reserved bits read nonzero");

  AST_ORDER: assert property (                                     // see R08
    stepNow && pickFound |=> slotIdx_r > $past(slotIdx_r))
    else $error("sequence went backwards");

  AST_FORMAT: assert property (                                    // see R09
    convSlot.active |-> convSlot.signedResult == convSlot.diff)
    else $error("result format does not match conversion type");

  AST_RANGE0: assert property (                                    // see R10
    convSlot.active && convSlot.channel == 4'h0 && !idle |->
      convSlot.rangeDouble == rangeSnap_r[15])
    else $error("channel 0 range not taken from bit 15");

  AST_RSV15: assert property (                                     // see R16
    regReq.wrEn && hitSrc |=> clrSource_r[15] == 1'b0 ##1 clrSource_r[15] == 1'b0)
    else $error("clear source bit 15 took a write");

  AST_SRC0_CLR: assert property (                                  // see R14
    clrSource_r[14] && alarmFlag_r[14] && autoClrEn_r[3] |=> dacForceClear[0])
    else $error("enabled channel 0 alarm did not clear dac 0");

  AST_NO_SRC: assert property (                                    // see R15
    clrSource_r[14:2] == 13'h0000 && $stable(clrSource_r) |=> dacForceClear == 12'h000)
    else $error("dac cleared with no source enabled");

  AST_FLAG: assert property (                                      // see R18
    alarmCond[14] |=> alarmFlag[14] ##1 (alarmFlag[14] == $past(alarmCond[14])))
    else $error("channel 0 flag does not follow condition");

  AST_FROZEN: assert property (                                    // see R20
    !idle && !startNow |=> $stable(maskSnap_r) && $stable(rangeSnap_r))
    else $error("sequence snapshot changed mid sequence");

  COV_DIFF_PAIR:  cover property (convSlot.active && convSlot.diff);
  COV_FULL_SEQ:   cover property (stepNow && !pickFound ##1 seqDone);
  COV_DAC_CLEAR:  cover property (anyHit && autoClrEn_r != 16'h0000 ##1
                                  dacForceClear != 12'h000);
  COV_MID_WRITE:  cover property (!idle && regReq.wrEn && hitLo);

endmodule : adc_range_ctrl

//--- adc_range_ctrl_tb_top.sv
// self-checking bench for the channel select, sequencing, range and alarm-clear block
// assumes the converter model answers slots; registers reached over the strobe port
`timescale 1ns/1ps
module adc_range_ctrl_tb_top;
  logic                      clk;
  logic                      reset_n;
  adc_range_pkg::reg_req_t   regReq;
  logic [15:0]               regRdData;
  logic                      seqStart;
  logic                      convDone;
  adc_range_pkg::conv_slot_t convSlot;
  logic                      seqDone;
  logic [14:2]               alarmCond;
  logic [14:2]               alarmFlag;
  logic [11:0]               dacForceClear;
  logic [3:0]                latency;
  logic [6:0]                gotQ[$];
  logic [6:0]                expQ[$];
  int                        miscompares;
  int                        n_compared;

  adc_range_ctrl DUT (.clk(clk), .reset_n(reset_n), .regReq(regReq), .regRdData(regRdData),
    .seqStart(seqStart), .convDone(convDone), .convSlot(convSlot), .seqDone(seqDone),
    .alarmCond(alarmCond), .alarmFlag(alarmFlag), .dacForceClear(dacForceClear));
  adc_converter_model conv (.clk(clk), .reset_n(reset_n), .convSlot(convSlot),
    .latency(latency), .convDone(convDone));

  always #12.5 clk = ~clk;

  // every slot the converter finishes, in the order they were handed out
  always @(posedge clk) begin
    if (convDone === 1'b1 && convSlot.active === 1'b1)
      gotQ.push_back({convSlot.diff, convSlot.rangeDouble, convSlot.signedResult,
                      convSlot.channel});
  end

  task automatic summarize();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic doReset();
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask : doReset

  // one-cycle strobes; a spare edge between accesses keeps each strobe a clean pulse
  task automatic regWrite(input logic [7:0] addr, input logic [15:0] data);
    @(posedge clk);
    regReq <= '{1'b1, 1'b0, addr, data};
    @(posedge clk);
    regReq <= '0;
  endtask : regWrite

  task automatic regRead(input logic [7:0] addr, output logic [15:0] data);
    @(posedge clk);
    regReq <= '{1'b0, 1'b1, addr, 16'h0000};
    @(posedge clk);
    regReq <= '0;
    #1 data = regRdData;
  endtask : regRead

  function automatic logic [6:0] slot(input logic d, input logic [3:0] ch,
                                      input logic [15:0] rng, input int rb);
    return {d, rng[rb], d, ch};
  endfunction : slot

  // expected slot order worked out from the select and range words
  function automatic void build(input logic [15:0] lo, input logic [15:0] hi,
                                input logic [15:0] rng);
    expQ.delete();
    if (lo[14]) expQ.push_back(slot(1'b0, 4'h0, rng, 15));
    if (lo[13]) expQ.push_back(slot(1'b0, 4'h1, rng, 14));
    if (lo[12] && !lo[14] && !lo[13]) expQ.push_back(slot(1'b1, 4'h0, rng, 15));
    if (lo[11]) expQ.push_back(slot(1'b0, 4'h2, rng, 13));
    if (lo[10]) expQ.push_back(slot(1'b0, 4'h3, rng, 12));
    if (lo[9] && !lo[11] && !lo[10]) expQ.push_back(slot(1'b1, 4'h2, rng, 13));
    for (int i = 8; i >= 0; i--)
      if (lo[i]) expQ.push_back(slot(1'b0, 4'(12 - i), rng, 3 + i));
    for (int i = 14; i >= 12; i--)
      if (hi[i]) expQ.push_back(slot(1'b0, 4'(27 - i), rng, i - 12));
  endfunction : build

  // runs one sequence; poke pulses start mid-run and rewrites the low select and range words
  task automatic runSeq(input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] rng,
                        input bit poke);
    int k;
    regWrite(8'h50, lo);
    regWrite(8'h51, hi);
    regWrite(8'h52, rng);
    build(lo, hi, rng);
    gotQ.delete();
    @(posedge clk);
    seqStart <= 1'b1;
    for (k = 0; k < 2000; k++) begin
      @(posedge clk);
      seqStart <= poke && (k == 3);  // ignored while busy
      // mid-run writes to select and range must wait for the next sequence
      if (poke && k == 4) regReq <= '{1'b1, 1'b0, 8'h50, 16'h0000};
      else if (poke && k == 6) regReq <= '{1'b1, 1'b0, 8'h52, 16'hFFFF};
      else regReq <= '0;
      #1;
      if (seqDone === 1'b1) break;
    end
    if (k == 2000) begin
      miscompares++;
      summarize();
    end
    check(16'(gotQ.size()), 16'(expQ.size()));
    for (int i = 0; i < expQ.size() && i < gotQ.size(); i++)
      check(16'(gotQ[i]), 16'(expQ[i]));
  endtask : runSeq

  // reset values, writable masks and the unmapped hole
  task automatic regScenario();
    logic [7:0]  adr[6] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h60};
    logic [15:0] rst[6] = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0004, 16'h0000, 16'h0000};
    logic [15:0] msk[6] = '{16'h7FFF, 16'h7000, 16'hFFFF, 16'h7FFC, 16'h7FF8, 16'h0000};
    logic [15:0] d;
    for (int i = 0; i < 6; i++) begin
      regRead(adr[i], d);
      check(d, rst[i]);
      regWrite(adr[i], 16'hFFFF);
      regRead(adr[i], d);
      check(d, msk[i]);
      regWrite(adr[i], 16'h0000);
      regRead(adr[i], d);
      check(d, 16'h0000);
    end
  endtask : regScenario

  // alarm flag follows the condition; forced clear needs source, enable and flag, or thermal source and flag
  task automatic alarmCase(input logic [15:0] src, input logic [15:0] en, input int b,
                           input logic [11:0] exp);
    regWrite(8'h53, src);
    regWrite(8'h54, en);
    @(posedge clk);
    alarmCond <= 13'(1 << (b - 2));
    @(posedge clk);
    #1 check(16'(alarmFlag), 16'(1 << (b - 2)));
    @(posedge clk);
    alarmCond <= '0;
    #1 check(16'(dacForceClear), 16'(exp));
    repeat (2) @(posedge clk);
    #1 check(16'(dacForceClear), 16'h0000);
  endtask : alarmCase

  initial begin
    clk         = 1'b0;
    reset_n     = 1'b0;
    regReq      = '0;
    seqStart    = 1'b0;
    alarmCond   = '0;
    latency     = 4'h0;
    miscompares = 0;
    n_compared  = 0;
    doReset();
    alarmCase(16'h0004, 16'h0000, 2, 12'hFFF);
    regScenario();
    doReset();
    // every combination of each pair's three select bits, pair 2/3 set to the complement of pair 0/1
    for (int i = 0; i < 8; i++)
      runSeq({1'b0, 3'(i), 3'(7 - i), 9'(9'h155 >> i)}, 16'h0000, 16'hA5C3 ^ 16'(i), 1'b0);
    latency = 4'h5;
    runSeq(16'h01FF, 16'h7000, 16'h0000, 1'b1);
    runSeq(16'h0000, 16'h0000, 16'hFFFF, 1'b0);
    latency = 4'h0;
    alarmCase(16'h4000, 16'h0008, 14, 12'h001);
    alarmCase(16'h2000, 16'h0010, 13, 12'h002);
    alarmCase(16'h1000, 16'h7FF8, 12, 12'hFFF);
    alarmCase(16'h0000, 16'h7FF8, 14, 12'h000);
    alarmCase(16'h4000, 16'h0000, 14, 12'h000);
    summarize();
  end
endmodule : adc_range_ctrl_tb_top

//--- adc_range_pkg.sv
// types shared by the channel configuration block and its helpers
// assumes adc_range_cfg.svh holds the numeric constants
package adc_range_pkg;

  // one register access from the serial host interface
  typedef struct packed {
    logic        wrEn;    // write strobe, one cycle
    logic        rdEn;    // read strobe, one cycle
    logic [7:0]  addr;    // register address
    logic [15:0] wrData;  // write data
  } reg_req_t;

  // conversion request handed to the converter
  typedef struct packed {
    logic       active;       // a slot is being converted
    logic [3:0] channel;      // channel and result register index
    logic       diff;         // differential pair conversion
    logic       rangeDouble;  // span of twice the reference
    logic       signedResult; // two's complement result
  } conv_slot_t;

  typedef enum logic {seqIdle, seqConvert} seq_state_t;

endpackage : adc_range_pkg

//--- pair_decode.sv
// single-ended versus differential decode for one channel pair
// assumes the three select bits come straight from a register
`timescale 1ns/1ps
module pair_decode (
  input  wire logic seA,     // single-ended select, lower channel
  input  wire logic seB,     // single-ended select, upper channel
  input  wire logic dfSel,   // differential pair select
  output logic      enA,     // convert lower channel single-ended
  output logic      enB,     // convert upper channel single-ended
  output logic      enDiff   // convert the difference
);

  // any single-ended bit wins, so the pair bit only counts when both are clear
  assign enA    = seA;                    // see R01 see R03
  assign enB    = seB;                    // see R01 see R03
  assign enDiff = dfSel & ~seA & ~seB;    // see R02 see R04 see R05

endmodule : pair_decode

//--- slot_picker.sv
// finds the first enabled conversion slot at or after a start index
// assumes mask bit 0 is the first slot of the sequence
`timescale 1ns/1ps
module slot_picker (
  input  wire logic [17:0] mask,     // enabled slots
  input  wire logic [4:0]  fromIdx,  // first slot to consider
  output logic             found,    // an enabled slot exists
  output logic [4:0]       pickIdx   // lowest enabled slot at or after fromIdx
);

  // scan from the top so the lowest qualifying slot is left standing
  always_comb begin
    found   = 1'b0;
    pickIdx = 5'h00;
    for (int i = 17; i >= 0; i--) begin
      if (mask[i] && (5'(i) >= fromIdx)) begin   // see R08
        found   = 1'b1;
        pickIdx = 5'(i);
      end
    end
  end

endmodule : slot_picker
